/* File: core/serial_register_access_port.sv */
// host serial port: spi-style frames and two-wire reads of 16-bit registers
// assumes async pins sampled by mclk_i; link clocks far slower than mclk_i
// Overview of operation
// - device returns upper byte then lower byte
// - acked lower byte repeats same register again
// - frame: flag bit 23, address, 16 data
// - shift input msb first on falling clock
// - chip-select high ignores clock, output tri-stated
// - rising chip-select decodes and updates register
// - flag 0 writes, flag 1 selects read
// - read data in next frame data field
// - extra clocks shift bits out on rising edge
// - two-wire pointer kept until new pointer byte
// - both bytes come from one snapshot
`timescale 1ns/1ns
`include "sra_params.svh"
module serial_register_access_port (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_i,
    // spi pins
    input  wire logic sclk_i,
    input  wire logic cs_n_i,
    input  wire logic sdi_i,
    output logic      sdo_o,
    output logic      sdo_oe_o,
    // two-wire pins
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_o
);
    typedef struct packed {
        logic [1:0]  sclk_s;
        logic [1:0]  cs_s;
        logic [1:0]  sdi_s;
        logic [1:0]  scl_s;
        logic [1:0]  sda_s;
        logic        sclk_d;
        logic        cs_d;
        logic        scl_d;
        logic        sda_d;
        logic [23:0] shreg;
        logic [15:0] rd_word;
        logic        rd_valid;
        logic [6:0]  rd_addr;
        logic [1:0]  upd_cnt;
        logic        upd_pend;
        logic [23:0] cmd;
        logic        sdo;
        logic        sdo_oe;
        sra_pkg::tw_state_type tw;
        logic [3:0]  bitn;
        logic [7:0]  rx;
        logic        dir_rd;
        logic [6:0]  ptr;
        logic [15:0] snap;
        logic        lowb;
        logic        sda;
        logic        sda_oe;
        logic        snap_req;
        logic        snap_take;
        logic        rdata_tw;
    } state_type;

    state_type q;
    state_type next_q;
    logic [15:0] rdata;
    logic        we;
    logic [6:0]  raddr;

    // two-wire has priority on the shared read port during a snap request and the whole read acknowledge state
    assign raddr = (q.tw == sra_pkg::tw_ack_r || q.snap_req) ? q.ptr : q.rd_addr;
    assign we    = q.upd_pend && (q.upd_cnt == 2'h0) && !q.cmd[`SRA_RW_BIT];

    sra_regfile #(.DEPTH(128)) regs (
        .mclk_i  (mclk_i),
        .waddr_i (q.cmd[`SRA_ADDR_MSB:`SRA_ADDR_LSB]),
        .wdata_i (q.cmd[`SRA_DATA_MSB:0]),
        .we_i    (we),
        .raddr_i (raddr),
        .rdata_o (rdata)
    );

    always_comb
    begin
        logic sclk_fall;
        logic sclk_rise;
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        sclk_fall = q.sclk_d && !q.sclk_s[1];
        sclk_rise = !q.sclk_d && q.sclk_s[1];
        scl_rise  = !q.scl_d && q.scl_s[1];
        scl_fall  = q.scl_d && !q.scl_s[1];
        start_c   = q.scl_s[1] && q.scl_d && q.sda_d && !q.sda_s[1];
        stop_c    = q.scl_s[1] && q.scl_d && !q.sda_d && q.sda_s[1];
        next_q = q;
        next_q.sclk_s = {q.sclk_s[0], sclk_i};
        next_q.cs_s   = {q.cs_s[0], cs_n_i};
        next_q.sdi_s  = {q.sdi_s[0], sdi_i};
        next_q.scl_s  = {q.scl_s[0], scl_i};
        next_q.sda_s  = {q.sda_s[0], sda_i};
        next_q.sclk_d = q.sclk_s[1];
        next_q.cs_d   = q.cs_s[1];
        next_q.scl_d  = q.scl_s[1];
        next_q.sda_d  = q.sda_s[1];

        // spi side
        next_q.sdo_oe = !q.cs_s[1];
        if (!q.cs_s[1])
        begin
            if (q.cs_d)
            begin
                // frame start: load read data or filler into data field
                next_q.shreg[`SRA_DATA_MSB:0] = q.rd_valid ? q.rd_word : 16'h0000;
                next_q.sdo = 1'b0;
            end
            else if (sclk_fall)
            begin
                next_q.shreg = {q.shreg[22:0], q.sdi_s[1]};
            end
            else if (sclk_rise)
            begin
                next_q.sdo = q.shreg[`SRA_FRAME_BITS-1];
            end
        end
        if (q.cs_s[1] && !q.cs_d)
        begin
            next_q.cmd      = q.shreg;
            next_q.upd_pend = 1'b1;
            next_q.upd_cnt  = 2'(`SRA_UPDATE_DELAY);
        end
        else if (q.upd_pend)
        begin
            if (q.upd_cnt != 2'h0)
            begin
                next_q.upd_cnt = q.upd_cnt - 2'h1;
            end
            else
            begin
                next_q.upd_pend = 1'b0;
                next_q.rd_valid = q.cmd[`SRA_RW_BIT];
                next_q.rd_addr  = q.cmd[`SRA_ADDR_MSB:`SRA_ADDR_LSB];
            end
        end
        if (q.rd_valid && !q.upd_pend && !q.rdata_tw)
        begin
            next_q.rd_word = rdata;
        end

        // two-wire read side
        // register port answers one cycle after the pointer is applied
        next_q.snap_req  = 1'b0;
        next_q.snap_take = q.snap_req;
        next_q.rdata_tw  = (q.tw == sra_pkg::tw_ack_r) || q.snap_req;
        if (q.snap_take)
        begin
            next_q.snap = rdata;
        end
        if (start_c)
        begin
            next_q.tw = sra_pkg::tw_addr;
            next_q.bitn = 4'h0;
            next_q.sda_oe = 1'b0;
        end
        else if (stop_c)
        begin
            next_q.tw = sra_pkg::tw_idle;
            next_q.sda_oe = 1'b0;
        end
        else
        begin
            case (q.tw)
                sra_pkg::tw_addr, sra_pkg::tw_ptr:
                begin
                    if (scl_rise)
                    begin
                        next_q.rx = {q.rx[6:0], q.sda_s[1]};
                        next_q.bitn = q.bitn + 4'h1;
                    end
                    if (scl_fall && q.bitn == 4'h8)
                    begin
                        next_q.bitn = 4'h0;
                        if (q.tw == sra_pkg::tw_ptr)
                        begin
                            next_q.ptr = q.rx[6:0];
                            next_q.tw = sra_pkg::tw_ack_w;
                            next_q.sda_oe = 1'b1;
                            next_q.sda = 1'b0;
                        end
                        else if (q.rx[7:1] == `SRA_I2C_ADDR)
                        begin
                            next_q.dir_rd = q.rx[0];
                            next_q.tw = sra_pkg::tw_ack_w;
                            next_q.sda_oe = 1'b1;
                            next_q.sda = 1'b0;
                            next_q.snap_req = q.rx[0];
                            next_q.lowb = 1'b0;
                        end
                        else
                        begin
                            next_q.tw = sra_pkg::tw_wait;
                        end
                    end
                end
                sra_pkg::tw_ack_w:
                begin
                    if (scl_fall)
                    begin
                        next_q.sda_oe = 1'b0;
                        if (q.dir_rd)
                        begin
                            next_q.tw = sra_pkg::tw_tx;
                            next_q.sda_oe = !q.snap[15];
                            next_q.bitn = 4'h1;
                        end
                        else
                        begin
                            next_q.tw = sra_pkg::tw_ptr;
                            next_q.dir_rd = 1'b0;
                        end
                    end
                end
                sra_pkg::tw_tx:
                begin
                    if (scl_fall)
                    begin
                        if (q.bitn == 4'h8)
                        begin
                            next_q.sda_oe = 1'b0;
                            next_q.tw = sra_pkg::tw_ack_r;
                        end
                        else
                        begin
                            // open drain: enable pulls low for a zero
                            next_q.sda_oe = !q.snap[(q.lowb ? 4'h7 : 4'hf) - q.bitn];
                            next_q.bitn = q.bitn + 4'h1;
                        end
                    end
                end
                sra_pkg::tw_ack_r:
                begin
                    if (scl_rise)
                    begin
                        if (q.sda_s[1])
                        begin
                            next_q.tw = sra_pkg::tw_wait;
                        end
                        else if (q.lowb)
                        begin
                            next_q.snap = rdata;
                            next_q.lowb = 1'b0;
                        end
                        else
                        begin
                            next_q.lowb = 1'b1;
                        end
                    end
                    if (scl_fall)
                    begin
                        next_q.tw = sra_pkg::tw_tx;
                        next_q.bitn = 4'h1;
                        next_q.sda_oe = !q.snap[q.lowb ? 4'h7 : 4'hf];
                    end
                end
                default:
                begin
                    next_q.sda_oe = 1'b0;
                end
            endcase
        end
        next_q.sda = 1'b0;
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q <= '{sclk_s: 2'h0, cs_s: 2'h3, sdi_s: 2'h0, scl_s: 2'h3, sda_s: 2'h3,
                   sclk_d: 1'b0, cs_d: 1'b1, scl_d: 1'b1, sda_d: 1'b1,
                   tw: sra_pkg::tw_idle, default: '0};
        end
        else
        begin
            q <= next_q;
        end
    end

    assign sdo_o    = q.sdo;
    assign sdo_oe_o = q.sdo_oe;
    assign sda_o    = q.sda;
    assign sda_oe_o = q.sda_oe;

    a_cs_high_tristate : assert property (@(posedge mclk_i) disable iff (rst_i)
        q.cs_s[1] && q.cs_d |=> !sdo_oe_o) else $error("sdo driven while deselected");
    a_cs_rise_update : assert property (@(posedge mclk_i) disable iff (rst_i)
        q.cs_s[1] && !q.cs_d && !q.shreg[23] |-> ##3 we) else $error("write not issued");
    a_read_latch : assert property (@(posedge mclk_i) disable iff (rst_i)
        q.upd_pend && q.upd_cnt == 2'h0 && q.cmd[`SRA_RW_BIT]
        |=> q.rd_valid && q.rd_addr == $past(q.cmd[`SRA_ADDR_MSB:`SRA_ADDR_LSB]))
        else $error("read address not latched");
    a_shift_in : assert property (@(posedge mclk_i) disable iff (rst_i)
        !q.cs_s[1] && !q.cs_d && q.sclk_d && !q.sclk_s[1] |=> q.shreg[0] == $past(q.sdi_s[1]))
        else $error("bit not shifted");
    a_sdo_rise : assert property (@(posedge mclk_i) disable iff (rst_i)
        !q.cs_s[1] && !q.cs_d && !q.sclk_d && q.sclk_s[1] |=> sdo_o == $past(q.shreg[23]))
        else $error("sdo not updated");
    a_nack_release : assert property (@(posedge mclk_i) disable iff (rst_i)
        q.tw == sra_pkg::tw_wait |-> !sda_oe_o) else $error("sda held after nack");
    a_rd_field : assert property (@(posedge mclk_i) disable iff (rst_i)
        q.cs_d && !q.cs_s[1] && !q.rd_valid |=> q.shreg[15:0] == 16'h0000)
        else $error("stale read data");
    a_ptr_hold : assert property (@(posedge mclk_i) disable iff (rst_i)
        q.tw != sra_pkg::tw_ptr |=> $stable(q.ptr)) else $error("pointer moved");
    c_spi_write : cover property (@(posedge mclk_i) we);
    c_spi_read : cover property (@(posedge mclk_i) q.rd_valid && q.cs_d && !q.cs_s[1]);
    c_tw_repeat : cover property (@(posedge mclk_i) q.tw == sra_pkg::tw_ack_r && q.lowb);
endmodule : serial_register_access_port

/* File: core/sra_params.svh */
// constants for the serial register access port
// assumes inclusion by bare name from core files
`ifndef SRA_PARAMS_SVH
`define SRA_PARAMS_SVH
`define SRA_FRAME_BITS     24
`define SRA_RW_BIT         23
`define SRA_ADDR_MSB       22
`define SRA_ADDR_LSB       16
`define SRA_DATA_MSB       15
`define SRA_I2C_ADDR       7'h2c
`define SRA_UPDATE_DELAY   2
`endif

/* File: core/sra_pkg.sv */
// types for the serial register access port
// assumes sra_params.svh beside it
package sra_pkg;
    typedef enum logic [2:0]
    {
        tw_idle  = 3'b000,
        tw_addr  = 3'b001,
        tw_ptr   = 3'b010,
        tw_tx    = 3'b011,
        tw_ack_w = 3'b100,
        tw_ack_r = 3'b101,
        tw_wait  = 3'b110
    } tw_state_type;
endpackage : sra_pkg

/* File: core/sra_regfile.sv */
// register storage behind both serial ports, 128 words of 16 bits
// assumes one clock domain; read data registered
`timescale 1ns/1ns
module sra_regfile #(
    parameter int DEPTH = 128
) (
    input  wire logic        mclk_i,
    input  wire logic [6:0]  waddr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        we_i,
    input  wire logic [6:0]  raddr_i,
    output logic      [15:0] rdata_o
);
    logic [15:0] mem [DEPTH];

    always_ff @(posedge mclk_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule : sra_regfile

/* File: dv/sra_host_model.sv */
// host controller model: spi frames and two-wire reads
// assumes mclk_i runs; pins change on falling mclk
`timescale 1ns/1ns
module sra_host_model (
    // clock
    input  wire logic mclk_i,
    // spi pins
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      sdi_o,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i,
    // two-wire pins, sda_o high releases the line
    output logic      scl_o,
    output logic      sda_o,
    input  wire logic sda_i
);
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o  = 1'b0;
        scl_o  = 1'b1;
        sda_o  = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : tick

    // n falling edges, 24 per device in a chain
    task automatic spi_frame(input int n, input logic [47:0] din, output logic [47:0] dout);
        dout   = '0;
        cs_n_o = 1'b0;
        tick(4);
        for (int i = n - 1; i >= 0; i--)
        begin
            sdi_o   = din[i];
            sclk_o  = 1'b1;
            tick(4);
            dout[i] = sdo_oe_i ? sdo_i : ~sdo_i; // undriven pin reads inverted
            sclk_o  = 1'b0;
            tick(4);
        end
        cs_n_o = 1'b1;
        sdi_o  = ~sdi_o; // no stale bit once deselected
        tick(10);
    endtask : spi_frame

    // refusal case: clock runs with chip-select high
    task automatic spi_noise(output logic oe_seen);
        oe_seen = 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            sdi_o  = i[1];
            sclk_o = ~sclk_o;
            tick(4);
            oe_seen |= sdo_oe_i;
        end
    endtask : spi_noise

    task automatic tw_start;
        sda_o = 1'b1;
        tick(3);
        scl_o = 1'b1;
        tick(4);
        sda_o = 1'b0;
        tick(4);
        scl_o = 1'b0;
        tick(3);
    endtask : tw_start

    task automatic tw_stop;
        sda_o = 1'b0;
        tick(3);
        scl_o = 1'b1;
        tick(4);
        sda_o = 1'b1;
        tick(4);
    endtask : tw_stop

    // eight data bits then the acknowledge slot
    task automatic tw_byte(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            sda_o = tx[i];
            tick(3);
            scl_o = 1'b1;
            tick(3);
            rx[i] = sda_i;
            tick(1);
            scl_o = 1'b0;
            tick(3);
        end
    endtask : tw_byte
endmodule : sra_host_model

/* File: dv/serial_register_access_port_tb_top.sv */
// testbench for the serial register access port
// assumes core files and host model compiled first
`timescale 1ns/1ns
`include "sra_params.svh"
module serial_register_access_port_tb_top;
    logic mclk_i, sclk, cs_n, sdi, sdo, sdo_oe, scl, sda_drv, sda_o, sda_oe;
    logic rst_i = 1'b1;
    int   error_cnt, comparisons;
    // pull-up wire, device only pulls low
    wire  sda_wire = sda_drv & ~sda_oe;

    serial_register_access_port dut (.mclk_i(mclk_i), .rst_i(rst_i), .sclk_i(sclk),
        .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .scl_i(scl),
        .sda_i(sda_wire), .sda_o(sda_o), .sda_oe_o(sda_oe));
    sra_host_model host (.mclk_i(mclk_i), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
        .sdo_i(sdo), .sdo_oe_i(sdo_oe), .scl_o(scl), .sda_o(sda_drv), .sda_i(sda_wire));

    initial
    begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic cmd(input logic rd, input logic [6:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        logic [47:0] o;
        host.spi_frame(24, {24'h000000, rd, a, d}, o);
        q = o[15:0];
    endtask : cmd

    task automatic sc_spi_rw;
        logic [15:0] q;
        cmd(1'b0, 7'h15, 16'ha55a, q);
        cmd(1'b0, 7'h2a, 16'h3cc3, q);
        cmd(1'b1, 7'h15, 16'hffff, q);
        chk("field after write", 24'h0, {8'h00, q});
        cmd(1'b1, 7'h2a, 16'h0000, q);
        chk("read 15", 24'h00a55a, {8'h00, q});
        cmd(1'b1, 7'h2a, 16'h0000, q);
        chk("read 2a", 24'h003cc3, {8'h00, q});
    endtask : sc_spi_rw

    task automatic sc_cs_high;
        logic        s;
        logic [15:0] q;
        host.spi_noise(s);
        chk("oe with cs high", 24'h0, {23'h0, s});
        cmd(1'b1, 7'h15, 16'h0000, q);
        cmd(1'b1, 7'h15, 16'h0000, q);
        chk("read after noise", 24'h00a55a, {8'h00, q});
    endtask : sc_cs_high

    task automatic sc_daisy;
        logic [47:0] o;
        logic [15:0] q;
        host.spi_frame(48, {1'b0, 7'h2a, 16'h1234, 1'b1, 7'h15, 16'h0000}, o);
        chk("chain out", {1'b0, 7'h2a, 16'h1234}, o[23:0]);
        cmd(1'b1, 7'h2a, 16'h0000, q);
        chk("kept frame", 24'h00a55a, {8'h00, q});
        cmd(1'b1, 7'h2a, 16'h0000, q);
        chk("passed frame", 24'h003cc3, {8'h00, q});
    endtask : sc_daisy

    // last lower byte gets nack, the others ack
    task automatic tw_rd(input int n);
        logic [8:0] r, h;
        host.tw_start();
        host.tw_byte({`SRA_I2C_ADDR, 1'b1, 1'b1}, r);
        chk("read addr ack", 24'h0, {23'h0, r[0]});
        for (int k = 0; k < n; k++)
        begin
            host.tw_byte(9'h1fe, h);
            host.tw_byte({8'hff, k == n - 1}, r);
            chk("two-wire word", 24'h00a55a, {8'h00, h[8:1], r[8:1]});
        end
        chk("released after nack", 24'h0, {23'h0, sda_oe});
        chk("sda level", 24'h0, {23'h0, sda_o});
        host.tw_stop();
    endtask : tw_rd

    task automatic sc_tw;
        logic [8:0] r;
        host.tw_start();
        host.tw_byte({`SRA_I2C_ADDR, 1'b0, 1'b1}, r);
        chk("write addr ack", 24'h0, {23'h0, r[0]});
        host.tw_byte({8'h15, 1'b1}, r);
        chk("pointer ack", 24'h0, {23'h0, r[0]});
        tw_rd(3);
        tw_rd(1);
    endtask : sc_tw

    task automatic close_out;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    initial
    begin
        repeat (16) @(negedge mclk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge mclk_i);
        sc_spi_rw();
        sc_cs_high();
        sc_daisy();
        sc_tw();
        close_out();
    end

    // tests need about 3500 cycles
    initial
    begin
        #1000000;
        error_cnt++;
        close_out();
    end
endmodule : serial_register_access_port_tb_top
